// ===== rtl/ovrd_detector.sv
`timescale 1ns/1ns
module ovrd_detector
    import ovrd_pkg::*;
(
    // clock and reset
    input  wire logic                    clock,
    input  wire logic                    resetn,
    // samples from the converter core
    input  wire ovrd_pkg::ovrd_sample_s  sample,
    // register port
    input  wire logic [11:0]             reg_addr,
    input  wire logic [7:0]              reg_wdata,
    input  wire logic                    reg_write,
    input  wire logic                    reg_read,
    output logic [7:0]                   reg_rdata,
    // overrange pins
    output logic                         chan_a_pin_zero,
    output logic                         chan_a_pin_one,
    output logic                         chan_b_pin_zero,
    output logic                         chan_b_pin_one,
    // interrupt
    output logic                         irq
);

    ////////////////////////////////////////////////////////////////////////////
    // registers

    logic [7:0]  overrange_threshold_zero;
    logic [7:0]  overrange_threshold_one;
    logic        overrange_pin_enable;
    logic [2:0]  pulse_length_exponent;
    logic [3:0]  irq_status;
    logic [3:0]  irq_enable;
    logic [7:0]  next_threshold_zero;
    logic [7:0]  next_threshold_one;
    logic        next_pin_enable;
    logic [2:0]  next_exponent;
    logic [3:0]  next_irq_status;
    logic [3:0]  next_irq_enable;
    logic [7:0]  next_rdata;

    ovrd_flags_s hits;
    ovrd_flags_s active;
    ovrd_flags_s pins;
    ovrd_flags_s next_pins;
    logic        next_irq;
    logic [10:0] pulse_length;

    ////////////////////////////////////////////////////////////////////////////
    // detection per channel

    ovrd_level u_level_a
    (
        .sample         (sample.a),
        .threshold_zero (overrange_threshold_zero),
        .threshold_one  (overrange_threshold_one),
        .hit_zero       (hits.chan_a_zero),
        .hit_one        (hits.chan_a_one)
    );

    ovrd_level u_level_b
    (
        .sample         (sample.b),
        .threshold_zero (overrange_threshold_zero),
        .threshold_one  (overrange_threshold_one),
        .hit_zero       (hits.chan_b_zero),
        .hit_one        (hits.chan_b_one)
    );

    ////////////////////////////////////////////////////////////////////////////
    // pulse stretching

    // length = base << exponent, at most 1024 cycles
    // the exponent is three bits, so the count never needs more than 11 bits
    assign pulse_length = 11'(ovrd_pulse_base) << pulse_length_exponent;

    // only valid samples count as hits
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_stretch
            ovrd_stretch u_stretch
            (
                .clock  (clock),
                .resetn (resetn),
                .hit    (sample.valid && hits[gi]),
                .length (pulse_length),
                .active (active[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // register write decode

    // write strobes, one per writable register
    logic        write_threshold_zero;
    logic        write_threshold_one;
    logic        write_output_config;
    logic        write_irq_enable;
    logic        write_irq_clear;

    // other offsets, the status byte included, decode to nothing,
    // so such writes are dropped
    assign write_threshold_zero = reg_write && (reg_addr == ovrd_addr_threshold_zero);
    assign write_threshold_one  = reg_write && (reg_addr == ovrd_addr_threshold_one);
    assign write_output_config  = reg_write && (reg_addr == ovrd_addr_output_config);
    assign write_irq_enable     = reg_write && (reg_addr == ovrd_addr_irq_enable);
    assign write_irq_clear      = reg_write && (reg_addr == ovrd_addr_irq_clear);

    ////////////////////////////////////////////////////////////////////////////
    // thresholds

    // plain read-write bytes; a new value applies from the next sample on
    // limitation: a threshold of zero flags every valid sample
    always_comb
    begin
        next_threshold_zero = overrange_threshold_zero;
        next_threshold_one  = overrange_threshold_one;
        if (write_threshold_zero)
            next_threshold_zero = reg_wdata;
        if (write_threshold_one)
            next_threshold_one = reg_wdata;
    end

    // thresholds leave reset at their default levels
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            overrange_threshold_zero <= ovrd_rst_threshold_zero;
            overrange_threshold_one  <= ovrd_rst_threshold_one;
        end
        else
        begin
            overrange_threshold_zero <= next_threshold_zero;
            overrange_threshold_one  <= next_threshold_one;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output configuration

    // reserved bits 7-4 are not stored and read back as zero; a new exponent
    // only sets the length of the next reload, a running pulse keeps its count
    always_comb
    begin
        next_pin_enable = overrange_pin_enable;
        next_exponent   = pulse_length_exponent;
        if (write_output_config)
        begin
            next_pin_enable = reg_wdata[ovrd_pin_enable_bit];
            next_exponent   = reg_wdata[ovrd_exponent_lsb +: 3];
        end
    end

    // pins start disabled with the longest pulse selected
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            overrange_pin_enable  <= ovrd_rst_pin_enable;
            pulse_length_exponent <= ovrd_rst_pulse_exponent;
        end
        else
        begin
            overrange_pin_enable  <= next_pin_enable;
            pulse_length_exponent <= next_exponent;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // hit qualification

    ovrd_flags_s qualified_hits;

    // a sample with valid low never sets a status bit; the stretchers
    // qualify their hits the same way, so pins and status agree
    assign qualified_hits = sample.valid ? hits : 4'h0;

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status and enable

    // status bits are sticky; a hit outweighs a clear of the same bit in one
    // cycle, so an event that lands on the clear is never lost; enable bits
    // only mask the line, status collects every hit regardless
    always_comb
    begin
        next_irq_enable = irq_enable;
        next_irq_status = irq_status;
        if (write_irq_enable)
            next_irq_enable = reg_wdata[3:0];
        if (write_irq_clear)
            next_irq_status = irq_status & ~reg_wdata[3:0];
        next_irq_status = next_irq_status | qualified_hits;
    end

    // status and enable share one reset
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            irq_status <= 4'h0;
            irq_enable <= ovrd_rst_irq_enable;
        end
        else
        begin
            irq_status <= next_irq_status;
            irq_enable <= next_irq_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt line

    // the line follows the new status at once, so it rises with the status
    // bit and never lags a read of the status register; a clear that empties
    // every enabled bit drops the line in the same edge
    always_comb
    begin
        next_irq = |(next_irq_status & next_irq_enable);
    end

    // level output from one flop, high while any enabled status bit is set
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            irq <= 1'b0;
        else
            irq <= next_irq;
    end

    ////////////////////////////////////////////////////////////////////////////
    // read port

    // value of the addressed register before the strobe gate
    logic [7:0]  read_value;

    // read mux; the clear register and unmapped offsets read zero, and a read
    // has no side effect, status bits clear only through the clear register
    always_comb
    begin
        read_value = 8'h00;
        case (reg_addr)
            ovrd_addr_threshold_zero: read_value = overrange_threshold_zero;
            ovrd_addr_threshold_one:  read_value = overrange_threshold_one;
            ovrd_addr_output_config:
                read_value = {4'h0, overrange_pin_enable, pulse_length_exponent};
            ovrd_addr_irq_status:     read_value = {4'h0, irq_status};
            ovrd_addr_irq_enable:     read_value = {4'h0, irq_enable};
            default:                  read_value = 8'h00;
        endcase
        // data stand for the one cycle after the strobe and are zero otherwise
        next_rdata = reg_read ? read_value : 8'h00;
    end

    // registered so the read data stand for exactly one cycle after the strobe
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            reg_rdata <= 8'h00;
        else
            reg_rdata <= next_rdata;
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin drive

    // pins gated as a group; while disabled the stretchers keep counting, so
    // enabling mid-pulse shows only the rest of that pulse
    always_comb
    begin
        if (overrange_pin_enable)
            next_pins = active;
        else
            next_pins = 4'h0;
    end

    // one flop per pin keeps the outputs free of decode glitches
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            pins <= 4'h0;
        else
            pins <= next_pins;
    end

    // pins straight from flip-flops
    // the struct keeps the b1 b0 a1 a0 order that the status bits use
    assign chan_a_pin_zero = pins.chan_a_zero;
    assign chan_a_pin_one  = pins.chan_a_one;
    assign chan_b_pin_zero = pins.chan_b_zero;
    assign chan_b_pin_one  = pins.chan_b_one;

endmodule

// ===== rtl/ovrd_level.sv
`timescale 1ns/1ns
// absolute level of one channel and its two threshold compares
module ovrd_level
    import ovrd_pkg::*;
(
    // sample
    input  wire logic signed [11:0] sample,
    // thresholds
    input  wire logic [7:0]         threshold_zero,
    input  wire logic [7:0]         threshold_one,
    // results
    output logic                    hit_zero,
    output logic                    hit_one
);
    logic [11:0] magnitude;
    logic [7:0]  level;

    // magnitude saturates at the top code, so -2048 reads as full scale
    always_comb
    begin
        if (sample[11])
            magnitude = (sample == 12'sh800) ? 12'h7ff : 12'(-sample);
        else
            magnitude = 12'(sample);
        level = magnitude[10:3];  // level / 256 of full scale
    end

    // reaching the threshold counts as crossing
    assign hit_zero = (level >= threshold_zero);
    assign hit_one  = (level >= threshold_one);
endmodule

// ===== rtl/ovrd_stretch.sv
`timescale 1ns/1ns
// stretches one overrange hit to a minimum pulse length
module ovrd_stretch
    import ovrd_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        resetn,
    // control
    input  wire logic        hit,
    input  wire logic [10:0] length,
    // pulse
    output logic             active
);
    logic [10:0] count;
    logic [10:0] next_count;

    // every new hit reloads the count, so a burst gives one long level
    always_comb
    begin
        next_count = count;
        if (hit)
            next_count = length;
        else if (count != 11'h000)
            next_count = count - 11'h001;
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            count <= 11'h000;
        else
            count <= next_count;
    end

    // high for exactly length cycles after the last hit
    assign active = (count != 11'h000);
endmodule

// ===== shared/ovrd_pkg.sv
package ovrd_pkg;

    // register map, byte-wide registers at their printed offsets
    localparam logic [11:0] ovrd_addr_threshold_zero = 12'h211;
    localparam logic [11:0] ovrd_addr_threshold_one  = 12'h212;
    localparam logic [11:0] ovrd_addr_output_config = 12'h213;
    localparam logic [11:0] ovrd_addr_irq_status     = 12'h214;
    localparam logic [11:0] ovrd_addr_irq_enable     = 12'h215;
    localparam logic [11:0] ovrd_addr_irq_clear      = 12'h216;

    // reset values
    localparam logic [7:0] ovrd_rst_threshold_zero = 8'hf2;
    localparam logic [7:0] ovrd_rst_threshold_one  = 8'hab;
    localparam logic [2:0] ovrd_rst_pulse_exponent = 3'h7;
    localparam logic       ovrd_rst_pin_enable     = 1'h0;
    localparam logic [3:0] ovrd_rst_irq_enable     = 4'h0;

    // config field positions
    localparam int ovrd_pin_enable_bit = 3;
    localparam int ovrd_exponent_lsb   = 0;

    // pulse length is base << exponent sample clocks
    localparam int          ovrd_pulse_base    = 8;
    localparam int          ovrd_count_width   = 11;
    localparam int          ovrd_sample_width  = 12;
    localparam int          ovrd_level_width   = 8;

    // one sample per channel
    typedef struct packed {
        logic                  valid;
        logic signed [11:0]    a;
        logic signed [11:0]    b;
    } ovrd_sample_s;

    // the four overrange lines, order b1 b0 a1 a0
    typedef struct packed {
        logic chan_b_one;
        logic chan_b_zero;
        logic chan_a_one;
        logic chan_a_zero;
    } ovrd_flags_s;

endpackage

// ===== verif/ovrd_detector_monitor.sv
`timescale 1ns/1ns
module ovrd_detector_monitor
    import ovrd_pkg::*;
(
    // clock and reset
    input wire logic                   clock,
    input wire logic                   resetn,
    // watched inputs
    input wire ovrd_pkg::ovrd_sample_s sample,
    input wire logic [11:0]            reg_addr,
    input wire logic [7:0]             reg_wdata,
    input wire logic                   reg_write,
    input wire logic                   reg_read,
    // watched outputs
    input wire logic [7:0]             reg_rdata,
    input wire logic                   chan_a_pin_zero,
    input wire logic                   chan_a_pin_one,
    input wire logic                   chan_b_pin_zero,
    input wire logic                   chan_b_pin_one,
    input wire logic                   irq
);
    logic       en_q;
    logic       next_en_q;
    logic       cfg_wr;
    logic       full_a;
    logic [3:0] pins;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////
    // shadow of the pin enable, so pin checks skip cycles around a toggle
    assign cfg_wr = reg_write && reg_addr == ovrd_addr_output_config;
    assign full_a = sample.valid && sample.a == 12'h7ff && en_q && !cfg_wr;
    assign pins = {chan_b_pin_one, chan_b_pin_zero, chan_a_pin_one, chan_a_pin_zero};
    always_comb
        next_en_q = cfg_wr ? reg_wdata[ovrd_pin_enable_bit] : en_q;
    always_ff @(posedge clock or negedge resetn)
        if (!resetn)
            en_q <= 1'h0;
        else
            en_q <= next_en_q;
    ////////////////////////////////////////
    a_pins_held_low:
        assert property (!$past(en_q) |-> pins == 4'h0) else $error("pin high while off");
    a_stretch_a_zero:
        assert property ($rose(chan_a_pin_zero) |=> chan_a_pin_zero [*7]) else $error("short");
    a_stretch_b_one:
        assert property ($rose(chan_b_pin_one) |=> chan_b_pin_one [*7]) else $error("short");
    a_full_hit_a:
        assert property (full_a |-> ##2 chan_a_pin_zero && chan_a_pin_one) else $error("miss");
    a_saturated_b:
        assert property (sample.valid && sample.b == 12'h800 && en_q && !cfg_wr
            |-> ##2 chan_b_pin_zero && chan_b_pin_one) else $error("saturation miss");
    a_hit_restarts:
        assert property (full_a ##1 chan_a_pin_zero |=> chan_a_pin_zero [*8]) else $error("gap");
    a_rise_has_cause:
        assert property ($rose(chan_a_pin_zero) |-> $past(sample.valid, 2)
            || $past(reg_write, 2)) else $error("pin rose alone");
    a_irq_has_cause:
        assert property ($rose(irq) |-> $past(sample.valid) || $past(reg_write))
            else $error("irq rose alone");
    // main scenarios
    cover property (full_a && chan_a_pin_zero);
    cover property ($fell(irq));
    cover property ($fell(chan_b_pin_one));
endmodule
bind ovrd_detector ovrd_detector_monitor ovrd_detector_monitor_inst (.clock(clock),
    .resetn(resetn), .sample(sample), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .chan_a_pin_zero(chan_a_pin_zero), .chan_a_pin_one(chan_a_pin_one),
    .chan_b_pin_zero(chan_b_pin_zero), .chan_b_pin_one(chan_b_pin_one), .irq(irq));

// ===== verif/ovrd_detector_tb.sv
`timescale 1ns/1ns
`define CHECK(got, want) begin checks_done++; if ((got) !== (want)) begin failures++; \
    $display("wrong value at %0t: %h not %h", $time, got, want); end end
module ovrd_detector_tb;
    import ovrd_pkg::*;
    logic         clock;
    logic         resetn;
    ovrd_sample_s sample;
    logic [11:0]  reg_addr;
    logic [7:0]   reg_wdata;
    logic         reg_write;
    logic         reg_read;
    logic [7:0]   reg_rdata;
    wire ovrd_flags_s pins;
    logic         irq;
    int           failures, checks_done, shortest, pulses;
    int           thr0, thr1, en, ex, ie, st, hits, la, lb, exp_pins, exp_irq, exp_rd;
    int           cnt [4];
    ovrd_detector ovrd_detector_inst (.clock(clock), .resetn(resetn), .sample(sample),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .chan_a_pin_zero(pins.chan_a_zero),
        .chan_a_pin_one(pins.chan_a_one), .chan_b_pin_zero(pins.chan_b_zero),
        .chan_b_pin_one(pins.chan_b_one), .irq(irq));
    ovrd_receiver ovrd_receiver_inst (.clock(clock), .resetn(resetn), .pins(pins),
        .shortest(shortest), .pulses(pulses));
    initial
    begin
        clock = 1'h0;
        forever #5 clock = ~clock;
    end
    ////////////////////////////////////////
    // level is magnitude over 8, so a threshold is a fraction of 256
    function automatic int lvl(logic signed [11:0] x);
        int m;
        m = x;
        m = m < 0 ? -m : m;
        return (m > 2047 ? 2047 : m) >> 3;
    endfunction
    function automatic int rd(logic [11:0] a);
        case (a)
            12'h211: return thr0;
            12'h212: return thr1;
            12'h213: return en * 8 + ex;
            12'h214: return st;
            12'h215: return ie;
            default: return 0;
        endcase
    endfunction
    // reference model, sees inputs as they stood before the edge
    always @(posedge clock or negedge resetn)
        if (!resetn)
        begin
            thr0 = 8'hf2;
            thr1 = 8'hab;
            ex = 7;
            en = 0;
            ie = 0;
            st = 0;
            exp_pins = 0;
            exp_irq = 0;
            exp_rd = 0;
            cnt = '{4{0}};
        end
        else
        begin
            for (int i = 0; i < 4; i++)
                exp_pins[i] = cnt[i] > 0 && en;
            exp_rd = reg_read ? rd(reg_addr) : 0;
            la = lvl(sample.a);
            lb = lvl(sample.b);
            hits = sample.valid ? (la >= thr0) + 2 * (la >= thr1) + 4 * (lb >= thr0)
                + 8 * (lb >= thr1) : 0;
            for (int i = 0; i < 4; i++)
                cnt[i] = hits[i] ? 8 << ex : (cnt[i] > 0 ? cnt[i] - 1 : 0);
            if (reg_write && reg_addr == 12'h216)
                st = st & ~reg_wdata;
            st = st | hits;
            if (reg_write && reg_addr == 12'h213)
                en = reg_wdata[3];
            if (reg_write && reg_addr == 12'h213)
                ex = reg_wdata[2:0];
            if (reg_write && reg_addr == 12'h211)
                thr0 = reg_wdata;
            if (reg_write && reg_addr == 12'h212)
                thr1 = reg_wdata;
            if (reg_write && reg_addr == 12'h215)
                ie = reg_wdata[3:0];
            // the line follows the updated status and enable in the same edge
            exp_irq = (st & ie) != 0;
        end
    // outputs compared once settled, every cycle
    always @(negedge clock)
        if (resetn)
        begin
            `CHECK(pins, exp_pins[3:0])
            `CHECK(irq, exp_irq[0])
            `CHECK(reg_rdata, exp_rd[7:0])
        end
    ////////////////////////////////////////
    task automatic step(logic v, logic [11:0] a, logic [11:0] b, logic w, logic r,
                        logic [11:0] ad, logic [7:0] d);
        @(posedge clock);
        sample <= {v, a, b};
        reg_write <= w;
        reg_read <= r;
        reg_addr <= ad;
        reg_wdata <= d;
    endtask
    task automatic idle(int n);
        repeat (n) step(0, 0, 0, 0, 0, 0, 0);
    endtask
    // config stays untouched here so pulse lengths stay predictable
    task automatic rnd_step();
        int op;
        logic [11:0] ad;
        op = $urandom % 4;
        ad = 12'h210 + 12'($urandom % 8);
        ad = ad == 12'h213 ? 12'h211 : ad;
        step(1'($urandom), 12'($urandom), 12'($urandom), op == 0, op == 1, ad, 8'($urandom));
    endtask
    task automatic report_and_stop();
        if (failures == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        {resetn, sample, reg_addr, reg_wdata, reg_write, reg_read} = '0;
        failures = 0;
        checks_done = 0;
        void'($urandom(69));
        repeat (6) @(posedge clock);
        resetn <= 1'h1;
        for (int a = 12'h210; a < 12'h218; a++)
            step(0, 0, 0, 0, 1, 12'(a), 0);
        step(0, 0, 0, 1, 0, 12'h214, 8'hff);
        step(0, 0, 0, 1, 0, 12'h215, 8'h0f);
        step(0, 0, 0, 1, 0, 12'h213, 8'h08);
        repeat (4) step(1, 12'h7ff, 12'h800, 0, 0, 0, 0);
        idle(30);
        // exponents 0 to 3 in turn, then pins switched off
        for (int k = 0; k < 5; k++)
        begin
            step(0, 0, 0, 1, 0, 12'h213, 8'(k < 4 ? 8 + k : 1));
            repeat (300) rnd_step();
            idle(80);
        end
        step(0, 0, 0, 1, 0, 12'h213, 8'h0f);
        step(1, 12'h7ff, 12'h800, 0, 0, 0, 0);
        idle(1100);
        `CHECK(pulses > 0 && shortest >= 8, 1'b1)
        report_and_stop();
    end
endmodule

// ===== verif/ovrd_receiver.sv
`timescale 1ns/1ns
module ovrd_receiver
(
    // clock and reset
    input wire logic       clock,
    input wire logic       resetn,
    // watched pins, order b1 b0 a1 a0
    input wire logic [3:0] pins,
    // shortest finished pulse and pulse count
    output int             shortest,
    output int             pulses
);
    int run [4];
    initial
    begin
        shortest = 100000;
        pulses = 0;
        run = '{4{0}};
    end
    // measures each high run; receiver logic only sees finished pulses
    always @(posedge clock)
        for (int i = 0; i < 4; i++)
            if (pins[i] === 1'b1)
                run[i] = run[i] + 1;
            else if (run[i] > 0)
            begin
                shortest = run[i] < shortest ? run[i] : shortest;
                pulses = pulses + 1;
                run[i] = 0;
            end
endmodule
